// ### src/gclm_counter.sv
module gclm_counter
    import gclm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic gate,
    input wire logic source,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic terminal_count
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rpend;
        logic [7:0] raddr;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] counter_mode_word;
        logic [15:0] count;
        logic armed;
        gclm_phase_e phase;
        logic tc;
        logic tc_seen;
        logic retrig_seen;
        logic gate_q;
        logic src_q;
        logic awready;
        logic wready;
        logic arready;
    } gclm_state_s;

    gclm_state_s st;
    gclm_state_s next_st;

    logic mem_we;
    logic mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [15:0] load_word;
    logic [15:0] hold_word;

    function automatic logic [2:0] mode_of(input logic [15:0] w);
        mode_of = w[15:gclm_mode_lsb];
    endfunction : mode_of

    function automatic logic gate_sel(input logic [15:0] w);
        gate_sel = (mode_of(w) == gclm_m_gatesel) || (mode_of(w) == gclm_m_fsk);
    endfunction : gate_sel

    function automatic logic edge_started(input logic [15:0] w);
        edge_started = (mode_of(w) == gclm_m_oneshot) || (mode_of(w) == gclm_m_hwsave);
    endfunction : edge_started

    // read port follows the address as it is taken, so data is ready a cycle later
    gclm_regs u_regs (
        .clk(clk),
        .rstn(rstn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(next_st.raddr == gclm_off_hold),
        .rdata(mem_rdata),
        .load_word(load_word),
        .hold_word(hold_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic gate_rise;
    logic src_rise;
    logic do_write;
    logic [2:0] mode;
    logic [15:0] reload_val;
    logic [15:0] cmd_bits;
    logic cmd_load;
    logic cmd_arm;
    logic cmd_disarm;
    logic cmd_reset;
    logic host_mem_we;
    logic [31:0] rd_word;
    logic hold_we;
    logic tc_event;

    always_comb begin
        next_st = st;
        mode = mode_of(st.counter_mode_word);
        gate_rise = gate && !st.gate_q;
        src_rise = source && !st.src_q;
        next_st.gate_q = gate;
        next_st.src_q = source;
        hold_we = gate_rise && st.armed && edge_started(st.counter_mode_word);
        tc_event = 1'b0;
        mem_we = 1'b0;
        mem_waddr = 1'b0;
        mem_wdata = 16'h0000;
        host_mem_we = 1'b0;
        rd_word = 32'h0000_0000;

        // bus write channel: address and data in either order
        if (s_axi_awvalid && !st.aw_got) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got) begin
            next_st.w_got = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        // a load write waits one cycle while a gate edge uses the hold port
        do_write = st.aw_got && st.w_got && !st.bvalid
            && !(hold_we && st.aw_addr == gclm_off_load);
        cmd_bits = (do_write && st.aw_addr == gclm_off_cmd && st.w_strb[0])
            ? st.w_data[15:0] : 16'h0000;
        cmd_load = cmd_bits[gclm_cmd_load];
        cmd_arm = cmd_bits[gclm_cmd_arm];
        cmd_disarm = cmd_bits[gclm_cmd_disarm];
        cmd_reset = cmd_bits[gclm_cmd_reset];

        // reload source choice
        if (!st.counter_mode_word[gclm_reload_sel_pos]) begin
            reload_val = load_word;
        end else if (gate_sel(st.counter_mode_word)) begin
            reload_val = gate ? hold_word : load_word;
        end else begin
            reload_val = load_word;
        end

        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = 2'b00;
            unique case (st.aw_addr)
                gclm_off_mode: begin
                    if (st.w_strb[0]) begin
                        next_st.counter_mode_word[7:0] = st.w_data[7:0];
                    end
                    if (st.w_strb[1]) begin
                        next_st.counter_mode_word[15:8] = st.w_data[15:8];
                    end
                end
                gclm_off_load: begin
                    host_mem_we = 1'b1;
                end
                gclm_off_cmd, gclm_off_status, gclm_off_count, gclm_off_hold: begin
                end
                default: next_st.bresp = 2'b10;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // counting engine
        if (hold_we) begin
            if (st.phase == gclm_idle || mode == gclm_m_oneshot) begin
                // one-shot retrigger, or start of save mode
                next_st.phase = (mode == gclm_m_oneshot) ? gclm_retrig : gclm_run;
            end
            mem_we = 1'b1;
            mem_waddr = 1'b1;
            mem_wdata = st.count;
            next_st.retrig_seen = 1'b1;
        end

        if (src_rise) begin
            if (st.tc) begin
                next_st.count = st.count - 16'h0001;
                next_st.tc = 1'b0;
            end else if (st.phase == gclm_retrig) begin
                next_st.count = load_word;
                next_st.phase = gclm_run;
            end else if ((st.phase == gclm_run && edge_started(st.counter_mode_word))
                || (st.armed && gate_sel(st.counter_mode_word))) begin
                if (st.count == 16'h0001) begin
                    next_st.tc = 1'b1;
                    next_st.tc_seen = 1'b1;
                    tc_event = 1'b1;
                    next_st.count = reload_val;
                    unique case (mode)
                        gclm_m_oneshot, gclm_m_hwsave: begin
                            next_st.phase = gclm_idle;
                            next_st.count = load_word;
                        end
                        gclm_m_gatesel: begin
                            if (st.phase == gclm_run) begin
                                next_st.armed = 1'b0;
                                next_st.phase = gclm_idle;
                            end else begin
                                next_st.phase = gclm_run;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else begin
                    next_st.count = st.count - 16'h0001;
                end
            end
        end

        // commands
        if (cmd_load) begin
            next_st.count = reload_val;
        end
        if (cmd_arm) begin
            next_st.armed = 1'b1;
            if (mode == gclm_m_gatesel) begin
                next_st.phase = gclm_idle;
            end
        end
        if (cmd_disarm) begin
            next_st.armed = 1'b0;
            next_st.phase = gclm_idle;
        end
        if (cmd_reset) begin
            next_st.counter_mode_word = gclm_mode_reset;
            next_st.armed = 1'b0;
            next_st.phase = gclm_idle;
        end
        if (host_mem_we && !mem_we) begin
            mem_we = 1'b1;
            mem_waddr = 1'b0;
            mem_wdata = st.w_data[15:0];
        end
        if (do_write && st.aw_addr == gclm_off_status) begin
            // write one to clear; a new event in the same cycle wins
            if (st.w_data[gclm_st_tc] && !tc_event) begin
                next_st.tc_seen = 1'b0;
            end
            if (st.w_data[gclm_st_retrig] && !hold_we) begin
                next_st.retrig_seen = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // bus read channel
        if (s_axi_arvalid && !st.rpend && !st.rvalid) begin
            next_st.rpend = 1'b1;
            next_st.raddr = s_axi_araddr;
        end
        if (st.rpend) begin
            next_st.rpend = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = 2'b00;
            unique case (st.raddr)
                gclm_off_mode: rd_word = {16'h0000, st.counter_mode_word};
                gclm_off_load, gclm_off_hold: rd_word = {16'h0000, mem_rdata};
                gclm_off_cmd: rd_word = 32'h0000_0000;
                gclm_off_status: rd_word = {28'h0000000, st.retrig_seen, st.tc_seen,
                    (st.phase != gclm_idle) || (st.armed && gate_sel(st.counter_mode_word)),
                    st.armed};
                gclm_off_count: rd_word = {16'h0000, st.count};
                default: next_st.rresp = 2'b10;
            endcase
            next_st.rdata = rd_word;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_got;
        next_st.wready = !next_st.w_got;
        next_st.arready = !next_st.rpend && !next_st.rvalid;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.counter_mode_word <= gclm_mode_reset;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // one-cycle delay between rpend and rvalid lets the memory read settle
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign terminal_count = st.tc;
endmodule : gclm_counter

// ### src/gclm_pkg.sv
package gclm_pkg;
    // register byte offsets
    localparam logic [7:0] gclm_off_mode = 8'h00;
    localparam logic [7:0] gclm_off_load = 8'h04;
    localparam logic [7:0] gclm_off_hold = 8'h08;
    localparam logic [7:0] gclm_off_cmd = 8'h0c;
    localparam logic [7:0] gclm_off_status = 8'h10;
    localparam logic [7:0] gclm_off_count = 8'h14;
    localparam logic [15:0] gclm_mode_reset = 16'h0800;
    // mode word fields
    localparam int gclm_mode_lsb = 13;
    localparam int gclm_reload_sel_pos = 6;
    localparam int gclm_repeat_pos = 5;
    // operating mode codes, mode word bits 15:13
    localparam logic [2:0] gclm_m_none = 3'h0;
    localparam logic [2:0] gclm_m_oneshot = 3'h1;
    localparam logic [2:0] gclm_m_gatesel = 3'h2;
    localparam logic [2:0] gclm_m_fsk = 3'h3;
    localparam logic [2:0] gclm_m_hwsave = 3'h4;
    // command register bits
    localparam int gclm_cmd_load = 0;
    localparam int gclm_cmd_arm = 1;
    localparam int gclm_cmd_disarm = 2;
    localparam int gclm_cmd_reset = 3;
    // status bits
    localparam int gclm_st_armed = 0;
    localparam int gclm_st_running = 1;
    localparam int gclm_st_tc = 2;
    localparam int gclm_st_retrig = 3;
    typedef enum logic [1:0] {
        gclm_idle = 2'b00,
        gclm_run = 2'b01,
        gclm_retrig = 2'b10
    } gclm_phase_e;
endpackage : gclm_pkg

// ### src/gclm_regs.sv
// small register memory: load and hold words, registered read
module gclm_regs
    import gclm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic waddr,
    input wire logic [15:0] wdata,
    input wire logic raddr,
    output logic [15:0] rdata,
    output logic [15:0] load_word,
    output logic [15:0] hold_word
);
    logic [15:0] mem [2];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem[0] <= 16'h0000;
            mem[1] <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

    assign load_word = mem[0];
    assign hold_word = mem[1];
endmodule : gclm_regs

// ### test/gclm_counter_assertions.sv
module gclm_counter_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic source,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic terminal_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_release: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write answer dropped");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("bad read response");
    a_tc_short: assert property (terminal_count && $rose(source)
        |-> ##[1:4] !terminal_count)
        else $error("terminal count too long");
    a_tc_cause: assert property ($rose(terminal_count) |->
        $past(source) || $past(source, 2) || $past(source, 3))
        else $error("terminal count without source edge");
endmodule : gclm_counter_assertions
bind gclm_counter gclm_counter_assertions u_chk (
    .clk(clk), .rstn(rstn), .source(source), .terminal_count(terminal_count),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ### test/gclm_counter_tb.sv
module gclm_counter_tb;
    import gclm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, gate, kick, busy, source, tc;
    logic [7:0] n, awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [1:0] last_bresp;
    int error_cnt = 0;
    int tests_run = 0;
    gclm_counter dut (.clk(clk), .rstn(rstn), .gate(gate), .source(source),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .terminal_count(tc));
    gclm_src_model src (.clk(clk), .rstn(rstn), .kick(kick), .n(n), .source(source),
        .busy(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        last_bresp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic chkr(input string what, input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(what, {16'h0000, exp}, d);
    endtask : chkr
    task automatic pulses(input logic [7:0] k);
        @(posedge clk);
        kick <= 1'b1;
        n <= k;
        @(posedge clk);
        kick <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : pulses
    task automatic gedge();
        @(posedge clk);
        gate <= 1'b1;
        repeat (4) @(posedge clk);
        gate <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : gedge
    ////////////////////////////////////////////////////////////////////////
    task automatic set_mode(input logic [15:0] m);
        wr(gclm_off_cmd, 32'h4);
        wr(gclm_off_mode, {16'h0000, m});
    endtask : set_mode
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        chkr("mode", gclm_off_mode, gclm_mode_reset);
        rd(8'h1c, d, r);
        chk("unmapped rresp", 32'h2, {30'h0, r});
        wr(8'h1c, 32'h0);
        chk("unmapped bresp", 32'h2, {30'h0, last_bresp});
        wr(gclm_off_mode, 32'h2000);
        chk("bresp", 32'h0, {30'h0, last_bresp});
        chkr("mode", gclm_off_mode, 16'h2000);
        wr(gclm_off_cmd, 32'h8);
        chkr("mode", gclm_off_mode, gclm_mode_reset);
    endtask : t_reset
    task automatic t_oneshot();
        set_mode(16'h2000);
        wr(gclm_off_load, 32'h3);
        wr(gclm_off_cmd, 32'h1);
        gedge();
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0003);
        chkr("hold", gclm_off_hold, 16'h0000);
        wr(gclm_off_cmd, 32'h2);
        gedge();
        chkr("hold", gclm_off_hold, 16'h0003);
        pulses(8'h01);
        chkr("count", gclm_off_count, 16'h0003);
        pulses(8'h03);
        chk("tc", 32'h1, {31'h0, tc});
        chkr("count", gclm_off_count, 16'h0003);
        pulses(8'h01);
        chk("tc", 32'h0, {31'h0, tc});
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0002);
        gedge();
        chkr("hold", gclm_off_hold, 16'h0002);
        pulses(8'h01);
        chkr("count", gclm_off_count, 16'h0003);
    endtask : t_oneshot
    task automatic t_hwsave();
        set_mode(16'h8000);
        wr(gclm_off_load, 32'h5);
        wr(gclm_off_cmd, 32'h3);
        gedge();
        pulses(8'h01);
        chkr("count", gclm_off_count, 16'h0004);
        gedge();
        chkr("hold", gclm_off_hold, 16'h0004);
        pulses(8'h04);
        chk("tc", 32'h1, {31'h0, tc});
        chkr("count", gclm_off_count, 16'h0005);
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0004);
        gedge();
        pulses(8'h01);
        chkr("count", gclm_off_count, 16'h0003);
    endtask : t_hwsave
    task automatic t_gatesel();
        set_mode(16'h4000);
        wr(gclm_off_load, 32'h2);
        gate <= 1'b1;
        wr(gclm_off_cmd, 32'h1);
        chkr("count", gclm_off_count, 16'h0002);
        set_mode(16'h4040);
        wr(gclm_off_cmd, 32'h1);
        chkr("count", gclm_off_count, 16'h0004);
        gate <= 1'b0;
        wr(gclm_off_cmd, 32'h1);
        chkr("count", gclm_off_count, 16'h0002);
        wr(gclm_off_status, 32'hc);
        wr(gclm_off_cmd, 32'h2);
        gate <= 1'b1;
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0004);
        gate <= 1'b0;
        pulses(8'h04);
        chkr("status", gclm_off_status, 16'h0004);
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0001);
    endtask : t_gatesel
    task automatic t_fsk();
        set_mode(16'h6040);
        gate <= 1'b1;
        wr(gclm_off_cmd, 32'h3);
        pulses(8'h04);
        chkr("count", gclm_off_count, 16'h0004);
        gate <= 1'b0;
        pulses(8'h08);
        chkr("count", gclm_off_count, 16'h0002);
        wr(gclm_off_status, 32'hf);
        chkr("status", gclm_off_status, 16'h0003);
        wr(gclm_off_cmd, 32'h4);
        pulses(8'h01);
        chkr("count", gclm_off_count, 16'h0001);
        pulses(8'h02);
        chkr("count", gclm_off_count, 16'h0001);
    endtask : t_fsk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {rstn, gate, kick, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        n = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_oneshot();
        t_hwsave();
        t_gatesel();
        t_fsk();
        wrap_up();
    end
endmodule : gclm_counter_tb

// ### test/gclm_src_model.sv
// source side: a burst of n pulses, four clocks high, four low
module gclm_src_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic kick,
    input wire logic [7:0] n,
    output logic source,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    logic [2:0] ph;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            left <= 8'h00;
            ph <= 3'h0;
            source <= 1'b0;
        end else if (kick) begin
            left <= n;
            ph <= 3'h0;
        end else if (left != 8'h00) begin
            ph <= ph + 3'h1;
            source <= (ph < 3'h4);
            if (ph == 3'h7) left <= left - 8'h01;
        end else begin
            source <= 1'b0;
        end
    end
    assign busy = (left != 8'h00);
endmodule : gclm_src_model
